// ### common/ict_regs.vh
// register map, field positions, reset values and timing counts of the interval counter timer
`ifndef ICT_REGS_VH
`define ICT_REGS_VH
// address width of the register port
`define ICT_AW 6
// start count write / latched count read, counter n at base + 4*n
`define ICT_CNT_BASE 6'h00
// per-counter control, counter n at base + 4*n
`define ICT_CTL_BASE 6'h10
// global control: clock source, latch command
`define ICT_GLB 6'h20
// interrupt status, write one to clear
`define ICT_IRQ 6'h24
// counter status readback
`define ICT_STAT 6'h28
// control fields
`define ICT_MODE_HI 2
`define ICT_MODE_LO 0
`define ICT_HWG 3
`define ICT_SWG 4
`define ICT_EXT 5
`define ICT_IEN 6
`define ICT_GINV 7
`define ICT_OINV 8
`define ICT_CTL_W 9
`define ICT_CTL_RST 9'h008
// global fields
`define ICT_CSRC 0
`define ICT_LAT_LO 4
`define ICT_LAT_HI 6
// status fields, one byte per counter
`define ICT_ST_OUT 0
`define ICT_ST_GATE 1
`define ICT_ST_RUN 2
`define ICT_ST_PEND 3
// modes
`define ICT_M_TC 3'h0
`define ICT_M_OS 3'h1
`define ICT_M_RATE 3'h2
`define ICT_M_SQ 3'h3
`define ICT_M_SWS 3'h4
`define ICT_M_HWS 3'h5
// clocks: the core clock serves as the bus clock
`define ICT_CORE_HZ 10000000
`define ICT_OSC_HZ 10000000
`define ICT_BUS_DIV 4
`define ICT_OSC_DIV (`ICT_CORE_HZ / `ICT_OSC_HZ)
`endif

// ### hdl/ict_top.v
// three-channel 32-bit interval counter timer with register port
//
// Functional notes
// - three independent 32-bit binary down-counters, no decimal mode
// - six modes 0..5, chosen per counter
// - mode 0: output low once programmed, until count reaches zero
// - mode 0: output stays high after zero until a new count or a mode 0 control word is written
// - mode 1: as mode 0 but gate edge starts or restarts the count
// - mode 2: one-clock low pulse at count 1, reload, period start plus 2
// - mode 2: interrupt flag at the end of each cycle
// - mode 3: high for first half of the count, low for the rest, repeating
// - mode 4: writing count starts it; one-clock low pulse when it expires
// - mode 4: new count written while counting loads on the next count clock
// - mode 5: as mode 4 but started and retriggered by gate edge
// - per-counter interrupt enable and readable interrupt status register
// - count clock is bus clock divided by four, the 10 MHz oscillator, or for counters 1 and 2 an external clock line
// - status readback per counter and a latch command freezing the count
// - gate inputs and outputs can be inverted by software
// - hardware gate line or software gate bit, gate state readable
// - each counter has its own gate input line and output line
`timescale 1ns/1ps
`include "ict_regs.vh"

module ict_top #(
  parameter CW = 32
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [`ICT_AW-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_timer0_gate_in,
  input wire i_timer1_gate_in,
  input wire i_timer2_gate_in,
  input wire i_timer1_ext_clock_in,
  input wire i_timer2_ext_clock_in,
  output wire o_timer0_output,
  output wire o_timer1_output,
  output wire o_timer2_output
);

  // each process owns its loop index so no variable has two drivers
  integer i;
  integer j;
  integer k;
  integer m;

  // counter state
  reg [CW-1:0] cnt [0:2];
  reg [CW-1:0] start_count_value [0:2];
  reg [CW-1:0] latch [0:2];
  reg [`ICT_CTL_W-1:0] ctl [0:2];
  reg [2:0] run;
  reg [2:0] ph;
  reg [2:0] out;
  reg [2:0] out_q;
  reg [2:0] ldp;
  reg [2:0] trp;
  reg [2:0] ev;
  reg [2:0] irq;
  reg [2:0] gt_q;
  reg csrc;

  // pin synchronisers
  reg [2:0] gs1;
  reg [2:0] gs2;
  reg [1:0] xs1;
  reg [1:0] xs2;
  reg [1:0] xs3;

  // count clock dividers
  reg [1:0] div_bus;
  reg [7:0] div_osc;
  reg int_tick;

  // derived per-counter terms
  reg [2:0] tk;
  reg [2:0] gt;
  reg [2:0] trg;

  // register port decode
  wire [3:0] widx;
  wire wr_cnt;
  wire wr_ctl;
  wire wr_glb;
  wire wr_irq;

  assign widx = {2'h0, i_addr[3:2]};
  assign wr_cnt = i_wr && (i_addr[5:4] == 2'h0) && (i_addr[3:2] != 2'h3);
  assign wr_ctl = i_wr && (i_addr[5:4] == 2'h1) && (i_addr[3:2] != 2'h3);
  assign wr_glb = i_wr && (i_addr == `ICT_GLB);
  assign wr_irq = i_wr && (i_addr == `ICT_IRQ);

  // outputs come straight from the registered polarity stage
  assign o_timer0_output = out_q[0];
  assign o_timer1_output = out_q[1];
  assign o_timer2_output = out_q[2];

  // two flip-flops on every field line before any logic looks at it
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gs1 <= 3'h0;
      gs2 <= 3'h0;
      xs1 <= 2'h0;
      xs2 <= 2'h0;
      xs3 <= 2'h0;
    end else begin
      gs1 <= {i_timer2_gate_in, i_timer1_gate_in, i_timer0_gate_in};
      gs2 <= gs1;
      xs1 <= {i_timer2_ext_clock_in, i_timer1_ext_clock_in};
      xs2 <= xs1;
      xs3 <= xs2;
    end
  end

  // internal count clock as a one-cycle enable
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_bus <= 2'h0;
      div_osc <= 8'h00;
      int_tick <= 1'b0;
    end else begin
      div_bus <= div_bus + 2'h1;
      if (div_osc == `ICT_OSC_DIV - 1)
        div_osc <= 8'h00;
      else
        div_osc <= div_osc + 8'h01;
      if (csrc)
        int_tick <= (div_osc == `ICT_OSC_DIV - 1);
      else
        int_tick <= (div_bus == `ICT_BUS_DIV - 1);
    end
  end

  // clock select, gate select and polarity per counter
  always @* begin
    tk = 3'h0;
    gt = 3'h0;
    trg = 3'h0;
    for (j = 0; j < 3; j = j + 1) begin
      // counter 0 has no external clock line
      if (j > 0 && ctl[j][`ICT_EXT])
        tk[j] = xs2[j-1] & ~xs3[j-1];
      else
        tk[j] = int_tick;
      if (ctl[j][`ICT_HWG])
        gt[j] = gs2[j] ^ ctl[j][`ICT_GINV];
      else
        gt[j] = ctl[j][`ICT_SWG] ^ ctl[j][`ICT_GINV];
      trg[j] = gt[j] & ~gt_q[j];
    end
  end

  // counter engines
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        cnt[i] <= {CW{1'b0}};
        start_count_value[i] <= {CW{1'b0}};
        latch[i] <= {CW{1'b0}};
        ctl[i] <= `ICT_CTL_RST;
      end
      run <= 3'h0;
      ph <= 3'h0;
      out <= 3'h0;
      ldp <= 3'h0;
      trp <= 3'h0;
      ev <= 3'h0;
      gt_q <= 3'h0;
      csrc <= 1'b0;
    end else begin
      ev <= 3'h0;
      gt_q <= gt;
      if (wr_glb)
        csrc <= i_wdata[`ICT_CSRC];
      for (i = 0; i < 3; i = i + 1) begin
        // gate edges are held until the next count clock uses them
        if (trg[i])
          trp[i] <= 1'b1;
        // latch freezes the live count for a consistent read
        if (wr_glb && i_wdata[`ICT_LAT_LO + i])
          latch[i] <= cnt[i];
        if (wr_ctl && widx == i) begin
          // a mode change stops the counter until a new count (modes 0, 2, 3, 4) or a gate edge (modes 1, 5) starts it
          ctl[i] <= i_wdata[`ICT_CTL_W-1:0];
          run[i] <= 1'b0;
          ph[i] <= 1'b0;
          ldp[i] <= 1'b0;
          trp[i] <= 1'b0;
          out[i] <= (i_wdata[`ICT_MODE_HI:`ICT_MODE_LO] != `ICT_M_TC);
        end else if (wr_cnt && widx == i) begin
          start_count_value[i] <= i_wdata[CW-1:0];
          ldp[i] <= 1'b1;
          if (ctl[i][`ICT_MODE_HI:`ICT_MODE_LO] == `ICT_M_TC) begin
            out[i] <= 1'b0;
            run[i] <= 1'b0;
          end
        end else if (tk[i]) begin
          case (ctl[i][`ICT_MODE_HI:`ICT_MODE_LO])
            `ICT_M_TC: begin
              if (ldp[i]) begin
                cnt[i] <= start_count_value[i];
                ldp[i] <= 1'b0;
                run[i] <= 1'b1;
              end else if (run[i] && gt[i]) begin
                if (cnt[i] <= 1) begin
                  cnt[i] <= {CW{1'b0}};
                  out[i] <= 1'b1;
                  run[i] <= 1'b0;
                  ev[i] <= 1'b1;
                end else begin
                  cnt[i] <= cnt[i] - 1'b1;
                end
              end
            end
            `ICT_M_OS: begin
              // the gate edge restarts; the gate level is not looked at
              if (trp[i] || trg[i]) begin
                cnt[i] <= start_count_value[i];
                trp[i] <= 1'b0;
                ldp[i] <= 1'b0;
                run[i] <= 1'b1;
                out[i] <= 1'b0;
              end else if (run[i]) begin
                if (cnt[i] <= 1) begin
                  cnt[i] <= {CW{1'b0}};
                  out[i] <= 1'b1;
                  run[i] <= 1'b0;
                  ev[i] <= 1'b1;
                end else begin
                  cnt[i] <= cnt[i] - 1'b1;
                end
              end
            end
            `ICT_M_RATE, `ICT_M_SQ: begin
              if (ldp[i]) begin
                cnt[i] <= start_count_value[i];
                ldp[i] <= 1'b0;
                run[i] <= 1'b1;
                ph[i] <= 1'b0;
                out[i] <= 1'b1;
              end else if (run[i] && gt[i]) begin
                if (cnt[i] > 1) begin
                  cnt[i] <= cnt[i] - 1'b1;
                  if (ctl[i][0])
                    out[i] <= ((cnt[i] - 1'b1) > (start_count_value[i] >> 1));
                end else if (cnt[i] == 1) begin
                  // low for exactly one count clock in mode 2
                  cnt[i] <= {CW{1'b0}};
                  ph[i] <= 1'b1;
                  out[i] <= 1'b0;
                end else if (ph[i]) begin
                  ph[i] <= 1'b0;
                  out[i] <= ctl[i][0] ? 1'b0 : 1'b1;
                end else begin
                  // reload: one cycle is start value plus two count clocks
                  cnt[i] <= start_count_value[i];
                  out[i] <= 1'b1;
                  ev[i] <= 1'b1;
                end
              end
            end
            `ICT_M_SWS, `ICT_M_HWS: begin
              if (ctl[i][0] ? (trp[i] || trg[i]) : ldp[i]) begin
                cnt[i] <= start_count_value[i];
                ldp[i] <= 1'b0;
                trp[i] <= 1'b0;
                run[i] <= 1'b1;
                ph[i] <= 1'b0;
                out[i] <= 1'b1;
              end else if (run[i] && (gt[i] || ctl[i][0])) begin
                if (ph[i]) begin
                  out[i] <= 1'b1;
                  ph[i] <= 1'b0;
                  run[i] <= 1'b0;
                  ev[i] <= 1'b1;
                end else if (cnt[i] <= 1) begin
                  cnt[i] <= {CW{1'b0}};
                  out[i] <= 1'b0;
                  ph[i] <= 1'b1;
                end else begin
                  cnt[i] <= cnt[i] - 1'b1;
                end
              end
            end
            default: begin
              // unused mode codes park the counter
              run[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq <= 3'h0;
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        if (ev[k] && ctl[k][`ICT_IEN])
          irq[k] <= 1'b1;
        else if (wr_irq && i_wdata[k])
          irq[k] <= 1'b0;
      end
    end
  end

  // output polarity stage
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      out_q <= 3'h0;
    end else begin
      for (m = 0; m < 3; m = m + 1)
        out_q[m] <= out[m] ^ ctl[m][`ICT_OINV];
    end
  end

  // read data stand in the cycle after the strobe only
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `ICT_CNT_BASE + 6'h00: o_rdata <= latch[0];
        `ICT_CNT_BASE + 6'h04: o_rdata <= latch[1];
        `ICT_CNT_BASE + 6'h08: o_rdata <= latch[2];
        `ICT_CTL_BASE + 6'h00: o_rdata <= {23'h000000, ctl[0]};
        `ICT_CTL_BASE + 6'h04: o_rdata <= {23'h000000, ctl[1]};
        `ICT_CTL_BASE + 6'h08: o_rdata <= {23'h000000, ctl[2]};
        `ICT_GLB: o_rdata <= {31'h00000000, csrc};
        `ICT_IRQ: o_rdata <= {29'h00000000, irq};
        `ICT_STAT: begin
          // gate state after selection and inversion is visible here
          o_rdata <= {8'h00,
                      4'h0, ldp[2], run[2], gt[2], out[2],
                      4'h0, ldp[1], run[1], gt[1], out[1],
                      4'h0, ldp[0], run[0], gt[0], out[0]};
        end
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule

// ### sim/ict_field_model.sv
// field side stand-in: gate lines and external count clock
`timescale 1ns/1ps
module ict_field_model (
  input wire [2:0] i_gate_req,
  input wire i_ext_run,
  output wire [2:0] o_gate,
  output reg o_ext_clk
);
  // gates move off the core edge, as a real field line would
  assign #37 o_gate = i_gate_req;
  // count clock near 2.7 MHz, held low when stopped
  initial o_ext_clk = 1'b0;
  always begin
    #185;
    o_ext_clk = i_ext_run ? ~o_ext_clk : 1'b0;
  end
endmodule

// ### sim/ict_top_asserts.sv
// concurrent checks on the interval counter timer ports
`timescale 1ns/1ps
`include "ict_regs.vh"
module ict_chk #(
  parameter CW = 32
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [`ICT_AW-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire o_timer0_output,
  input wire o_timer1_output
);
  reg [2:0] mode0;
  reg inv0;
  wire w0 = i_wr && (i_addr == 6'h00 || i_addr == 6'h10);
  // shadow of counter 0 control so mode checks know what applies
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mode0 <= 3'h0;
      inv0 <= 1'b0;
    end else if (i_wr && i_addr == 6'h10) begin
      mode0 <= i_wdata[2:0];
      inv0 <= i_wdata[8];
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // counter 0 control write selecting mode 0
  sequence ctl0_m0_s;
    i_wr && i_addr == 6'h10 && i_wdata[2:0] == 3'h0;
  endsequence
  rd_idle_zero_a:
    assert property (!i_rd |=> o_rdata == 32'h0) else $error("idle read data not zero");
  unmapped_rd_a:
    assert property (i_rd && (i_addr == 6'h0C || i_addr == 6'h1C) |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  preset_low_a:
    assert property (ctl0_m0_s ##0 !i_wdata[8] |-> ##[1:3] !o_timer0_output) else $error("output not low");
  out_invert_a:
    assert property (ctl0_m0_s ##0 i_wdata[8] |-> ##[1:3] o_timer0_output) else $error("output not inverted");
  preset_high_a:
    assert property (i_wr && i_addr == 6'h14 && i_wdata[2:0] >= 3'h2 && i_wdata[2:0] <= 3'h5 && !i_wdata[8]
      |-> ##[1:3] o_timer1_output) else $error("counter 1 output not high");
  count_low_a:
    assert property (i_wr && i_addr == 6'h00 && mode0 == 3'h0 && !inv0 |-> ##[1:3] !o_timer0_output)
    else $error("count write left output high");
  tc_hold_a:
    assert property (mode0 == 3'h0 && !inv0 && o_timer0_output && !w0 && !$past(w0) |=> o_timer0_output)
    else $error("terminal count output dropped");
  pulse_short_a:
    assert property ((mode0 == 3'h2 || mode0 == 3'h4) && !inv0 && $fell(o_timer0_output)
      |-> ##[1:4] o_timer0_output) else $error("strobe pulse too long");
endmodule
bind ict_top ict_chk #(.CW(CW)) ict_chk_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_timer0_output(o_timer0_output),
  .o_timer1_output(o_timer1_output));

// ### sim/tb_ict_top.sv
// self-checking bench for the interval counter timer
`timescale 1ns/1ps
`include "ict_regs.vh"
module tb_ict_top;
  reg i_core_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [`ICT_AW-1:0] i_addr = 6'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [2:0] gate_req = 3'h0;
  reg ext_run = 1'b0;
  reg rd_q = 1'b0;
  wire [31:0] o_rdata;
  wire [2:0] gate;
  wire [2:0] out;
  wire ext_clk;
  int mismatches = 0;
  int n_checks = 0;
  int n;
  int p;
  logic [31:0] qe[$];
  logic [31:0] qm[$];
  logic [31:0] v1;
  logic [31:0] v2;
  always #50 i_core_clk = ~i_core_clk;
  ict_top ict_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer0_gate_in(gate[0]), .i_timer1_gate_in(gate[1]),
    .i_timer2_gate_in(gate[2]), .i_timer1_ext_clock_in(ext_clk), .i_timer2_ext_clock_in(ext_clk),
    .o_timer0_output(out[0]), .o_timer1_output(out[1]), .o_timer2_output(out[2]));
  ict_field_model ict_field_model_inst (.i_gate_req(gate_req), .i_ext_run(ext_run), .o_gate(gate),
    .o_ext_clk(ext_clk));
  task conclude;
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // one-cycle strobes, driven just after the edge
  task wr(input [5:0] a, input [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    // the pin lags the counter state by a cycle, so let one edge pass before looking
    @(posedge i_core_clk);
  endtask
  task rd(input [5:0] a, input [31:0] e, input [31:0] m);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    qe.push_back(e);
    qm.push_back(m);
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask
  task rdv(input [5:0] a, output [31:0] v);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    v = o_rdata;
  endtask
  // bounded wait for a pin level; a miss ends the run
  task wt(input int i, input logic l, input int lim, output int c);
    c = 0;
    while (out[i] !== l) begin
      @(negedge i_core_clk);
      c++;
      if (c > lim) begin
        chk("timeout", 32'h0, 32'h1);
        conclude;
      end
    end
  endtask
  task hold(input int i, input logic l, input int k);
    int bad;
    bad = 0;
    repeat (k) begin
      @(negedge i_core_clk);
      if (out[i] !== l) bad++;
    end
    chk("hold", 32'h0, bad);
  endtask
  task per(input int i, output int t);
    int c;
    wt(i, 1'b1, 200, c);
    wt(i, 1'b0, 200, c);
    wt(i, 1'b1, 200, t);
    wt(i, 1'b0, 200, c);
    t += c;
  endtask
  // read data stands only in the cycle after the strobe, so look mid-cycle
  always @(posedge i_core_clk) rd_q <= i_rd;
  always @(negedge i_core_clk) begin
    if (rd_q && qe.size() > 0) begin
      chk("rdata", qe[0], o_rdata & qm[0]);
      void'(qe.pop_front());
      void'(qm.pop_front());
    end
  end
  initial begin
    n = $urandom(3634);
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    wr(6'h0C, 32'hFFFFFFFF);
    for (int a = 0; a < 48; a += 4) rd(a[5:0], (a >= 16 && a < 28) ? 32'h8 : 32'h0, 32'hFFFFFFFF);
    gate_req <= 3'h7;
    wr(`ICT_GLB, 32'h1);
    wr(6'h10, 32'h048);
    wr(6'h00, 32'h5);
    hold(0, 1'b0, 3);
    wt(0, 1'b1, 20, p);
    hold(0, 1'b1, 10);
    rd(6'h24, 32'h1, 32'h7);
    wr(6'h24, 32'h1);
    rd(6'h24, 32'h0, 32'h7);
    gate_req <= 3'h6;
    hold(0, 1'b1, 3);
    wr(6'h00, 32'h5);
    hold(0, 1'b0, 30);
    gate_req <= 3'h7;
    wt(0, 1'b1, 20, p);
    wr(6'h10, 32'h010);
    rd(6'h28, 32'h2, 32'h2);
    gate_req <= 3'h6;
    wr(6'h10, 32'h088);
    hold(0, 1'b0, 3);
    rd(6'h28, 32'h2, 32'h2);
    wr(6'h10, 32'h100);
    hold(0, 1'b1, 3);
    // latch twice while the gate holds the count still
    wr(6'h10, 32'h008);
    wr(6'h00, 32'd1000);
    gate_req <= 3'h7;
    hold(0, 1'b0, 20);
    gate_req <= 3'h6;
    hold(0, 1'b0, 5);
    wr(`ICT_GLB, 32'h11);
    rdv(6'h00, v1);
    wr(`ICT_GLB, 32'h11);
    rdv(6'h00, v2);
    chk("latch", 32'h1, {31'h0, v1 > 950 && v1 < 1000 && v2 === v1});
    gate_req <= 3'h7;
    // earlier terminal counts left counter 0 pending; clear so the tick flag proves itself
    wr(6'h24, 32'h7);
    n = $urandom_range(9, 2);
    wr(6'h10, 32'h04A);
    wr(6'h00, n);
    per(0, p);
    chk("period", n + 2, p);
    rd(6'h24, 32'h1, 32'h1);
    wr(`ICT_GLB, 32'h0);
    per(0, p);
    per(0, p);
    chk("period", 4 * (n + 2), p);
    wr(`ICT_GLB, 32'h1);
    wr(6'h14, 32'h00B);
    wr(6'h04, n);
    per(1, p);
    chk("period", n + 2, p);
    wr(6'h18, 32'h00C);
    wr(6'h08, 32'h6);
    wt(2, 1'b0, 20, p);
    wt(2, 1'b1, 3, p);
    chk("pulse", 32'h1, p);
    hold(2, 1'b1, 20);
    wr(6'h08, 32'd60);
    hold(2, 1'b1, 5);
    wr(6'h08, 32'h3);
    wt(2, 1'b0, 10, p);
    gate_req <= 3'h5;
    wr(6'h14, 32'h00D);
    wr(6'h04, 32'h4);
    hold(1, 1'b1, 30);
    gate_req <= 3'h7;
    wt(1, 1'b0, 20, p);
    gate_req <= 3'h5;
    wr(6'h14, 32'h009);
    wr(6'h04, 32'h4);
    hold(1, 1'b1, 10);
    gate_req <= 3'h7;
    wt(1, 1'b0, 10, p);
    wt(1, 1'b1, 20, p);
    // external clock selection: counter 0 ignores it, counter 1 waits for it
    wr(6'h10, 32'h02A);
    wr(6'h00, 32'h3);
    wt(0, 1'b0, 30, p);
    wr(6'h14, 32'h02A);
    wr(6'h04, 32'h3);
    hold(1, 1'b1, 40);
    ext_run <= 1'b1;
    wt(1, 1'b0, 60, p);
    ext_run <= 1'b0;
    conclude;
  end
endmodule
